// file: hw/power_mode_controller.sv
/*
 * operating-mode controller: init, normal, stop, sleep, restart and
 * fail-safe, with apb registers, wake handling and locks.
 * assumes supply comparators and wake pins are asynchronous levels,
 * and timer, watchdog fail and fail-safe requests come from this clock.
 */
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "power_mode_consts.svh"

module power_mode_controller #(
	parameter int RESET_DELAY_NS = `RESET_DELAY_NS
) (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       nrst,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output logic [31:0]                     prdata,
	output logic                            pready,
	output logic                            pslverr,
	// asynchronous monitors and wake pins
	input  wire logic                       main_below_reset_threshold,
	input  wire logic                       battery_below_uv,
	input  wire logic                       xcvr_wake,
	input  wire logic                       wake_sense_pin,
	input  wire logic                       gpio_wake,
	// same-clock events
	input  wire logic                       timer_wake,
	input  wire logic                       watchdog_fail,
	input  wire logic                       failsafe_req,
	// outputs
	output power_mode_pkg::pin_out_type     pins,
	output power_mode_pkg::mode_state_type  mode,
	output logic                            reset_output_n,
	output logic                            interrupt_output_n,
	output logic                            fail_output_n,
	output logic                            watchdog_refresh
);

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int RD_CYC  = (RESET_DELAY_NS + `CLK_NS - 1) / `CLK_NS;
	localparam int INT_CYC = (`INT_PULSE_NS + `CLK_NS - 1) / `CLK_NS;

	// elaboration check: the delay counter is only 16 bits wide
	if (RD_CYC < 1 || RD_CYC > 65535) begin
		$error("reset delay out of counter range");
	end

	// state names held locally, since nothing is imported
	typedef power_mode_pkg::mode_state_type mstate_type;
	localparam mstate_type st_init     = power_mode_pkg::st_init;
	localparam mstate_type st_normal   = power_mode_pkg::st_normal;
	localparam mstate_type st_stop     = power_mode_pkg::st_stop;
	localparam mstate_type st_sleep    = power_mode_pkg::st_sleep;
	localparam mstate_type st_restart  = power_mode_pkg::st_restart;
	localparam mstate_type st_failsafe = power_mode_pkg::st_failsafe;

	// -----------------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------------
	logic [4:0] sync1_ff;   // first stage, read only by second
	logic [4:0] sync2_ff;   // usable levels
	logic [4:0] sync3_ff;   // previous level for edge detect

	always_ff @(posedge clock) begin
		sync1_ff <= {main_below_reset_threshold, battery_below_uv,
			xcvr_wake, wake_sense_pin, gpio_wake};
		sync2_ff <= sync1_ff;
		sync3_ff <= sync2_ff;
	end

	wire logic main_uv = sync2_ff[4];
	wire logic bat_uv  = sync2_ff[3];
	wire logic [2:0] rise = sync2_ff[2:0] & ~sync3_ff[2:0];

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	power_mode_pkg::mode_state_type  state_ff, nxt_state;
	power_mode_pkg::supply_ctrl_type ctrl_ff, nxt_ctrl;
	power_mode_pkg::wake_type        wflag_ff, nxt_wflag;
	logic [1:0]  dev_ff, nxt_dev;         // device_mode_status
	logic        err_ff, nxt_err;         // command error flag
	logic        muv_ff, nxt_muv;         // main_undervolt_flag
	logic        buv_ff, nxt_buv;         // battery_undervolt_flag
	logic        failure_ff, nxt_failure; // failure flag
	logic        test_ff, nxt_test;       // fail_output_test_bit
	logic        prot_ff, nxt_prot;       // protection lock
	logic        cfg_ff, nxt_cfg;         // configuration lock
	logic        armed_ff;                // first release seen
	logic [15:0] rd_cnt_ff;               // reset delay counter
	logic [7:0]  int_cnt_ff;              // interrupt pulse counter
	logic        rst_n_ff;
	logic [31:0] rdata_ff;

	// -----------------------------------------------------------------
	// apb decode
	// -----------------------------------------------------------------
	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		hit = (a == o);
	endfunction

	wire logic acc    = psel & penable;
	wire logic wr     = acc & pwrite;
	wire logic a_mode = hit(paddr, `OFS_MODE_CTRL);
	wire logic a_sup  = hit(paddr, `OFS_SUPPLY_CTRL);
	wire logic a_lock = hit(paddr, `OFS_LOCK_CTRL);
	wire logic a_wake = hit(paddr, `OFS_WAKE_STAT);
	wire logic a_dev  = hit(paddr, `OFS_DEVICE_MODE_STATUS);
	wire logic a_wd   = hit(paddr, `OFS_WD_REFRESH);
	wire logic mapped = a_mode | a_sup | a_lock | a_wake | a_dev | a_wd;
	wire logic [1:0] req = pwdata[1:0];

	// writes that stop mode still accepts
	wire logic stop_ok = a_wd | a_wake | a_dev | (a_mode &
		(req == `MODE_NORMAL || req == `MODE_SOFT));
	wire logic in_init = (state_ff == st_init);
	wire logic in_norm = (state_ff == st_normal);
	wire logic in_stop = (state_ff == st_stop);
	// apb writes are ignored in restart, sleep and fail-safe
	wire logic wr_ok  = wr & mapped & (in_init | in_norm |
		(in_stop & stop_ok));
	wire logic stop_bad = wr & in_stop & ~stop_ok;

	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;
	assign prdata  = rdata_ff;
	assign watchdog_refresh = wr_ok & a_wd;

	// read multiplexer, captured in the setup cycle
	wire logic [31:0] rmux =
		a_mode ? {29'h0, test_ff, 2'h0} :
		a_sup  ? {20'h0, ctrl_ff} :
		a_lock ? {30'h0, cfg_ff, prot_ff} :
		a_wake ? {28'h0, wflag_ff} :
		a_dev  ? {23'h0, state_ff, failure_ff, buv_ff, muv_ff, err_ff,
			dev_ff} : 32'h0;

	// -----------------------------------------------------------------
	// wake sources
	// -----------------------------------------------------------------
	// pins serve measurement instead of waking when routed
	wire logic meas   = ctrl_ff.measure_route_enable;
	wire logic en_x   = (ctrl_ff.xcvr_mode != `XCVR_OFF);
	wire logic en_p   = ctrl_ff.pin_wake_en & ~meas;
	wire logic en_g   = (ctrl_ff.gpio_cfg == `GPIO_WAKE) & ~meas;
	wire logic en_t   = ctrl_ff.timer_wake_en | ctrl_ff.cyclic_wake_en;
	wire logic any_en = en_x | en_p | en_g | en_t;
	power_mode_pkg::wake_type wev;
	assign wev = '{timer: timer_wake & en_t, gpio: rise[0] & en_g,
		pin: rise[1] & en_p, xcvr: rise[2] & en_x};
	wire logic wake_now = |wev;
	wire logic flags_set = |wflag_ff;

	// -----------------------------------------------------------------
	// reset output timing
	// -----------------------------------------------------------------
	// restart entry pulls reset low at once and restarts the delay
	wire logic go_restart_edge = (nxt_state == st_restart) &
		(state_ff != st_restart);
	wire logic rd_done = (rd_cnt_ff == 16'(RD_CYC));
	wire logic hold_rst = (state_ff == st_sleep) |
		(state_ff == st_failsafe) | go_restart_edge;

	// -----------------------------------------------------------------
	// mode state machine and register updates
	// -----------------------------------------------------------------
	always_comb begin
		logic [11:0] lk;
		logic        go_restart;
		lk          = prot_ff ? 12'hfff :
			(cfg_ff ? `CTRL_CFG_MASK : 12'h000);
		go_restart  = 1'b0;
		nxt_state   = state_ff;
		nxt_ctrl    = ctrl_ff;
		nxt_wflag   = wflag_ff;
		nxt_dev     = dev_ff;
		nxt_err     = err_ff;
		nxt_muv     = muv_ff;
		nxt_buv     = buv_ff;
		nxt_failure = failure_ff;
		nxt_test    = test_ff;
		nxt_prot    = prot_ff;
		nxt_cfg     = cfg_ff;

		// software clears first, so hardware sets below win
		if (wr_ok & a_wake)
			nxt_wflag = wflag_ff & ~pwdata[3:0];
		if (wr_ok & a_dev) begin
			if (pwdata[`POS_CMD_ERR]) nxt_err = 1'b0;
			if (pwdata[`POS_MAIN_UV]) nxt_muv = 1'b0;
			if (pwdata[`POS_BAT_UV])  nxt_buv = 1'b0;
			if (pwdata[`POS_FAILURE]) nxt_failure = 1'b0;
			if (pwdata[1:0] != 2'h0)  nxt_dev = 2'h0;
		end
		// configuration only in init and normal; stop freezes it
		if (wr_ok & a_sup & ~in_stop)
			nxt_ctrl = (ctrl_ff & lk) | (pwdata[11:0] & ~lk);
		if (wr_ok & a_lock & ~in_stop) begin
			if (pwdata[`POS_LOCK_PROT]) nxt_prot = 1'b1;
			nxt_cfg = pwdata[`POS_LOCK_CFG] |
				(cfg_ff & ~in_norm);
		end
		if (wr_ok & a_mode & ~in_stop)
			nxt_test = pwdata[`POS_FAIL_TEST];

		// wake flags record in normal, stop, sleep and fail-safe
		if (~in_init & state_ff != st_restart)
			nxt_wflag = nxt_wflag | wev;

		// battery flag only in init after release
		if (in_init & rst_n_ff & bat_uv)
			nxt_buv = 1'b1;
		if (stop_bad)
			nxt_err = 1'b1;
		if (watchdog_fail)
			nxt_failure = 1'b1;

		case (state_ff)
			st_init: begin
				if (acc & rst_n_ff)
					nxt_state = st_normal;
			end
			st_normal: begin
				if (wr_ok & a_mode) begin
					case (req)
						`MODE_STOP: nxt_state = st_stop;
						`MODE_SLEEP: begin
							if (any_en) begin
								nxt_state = st_sleep;
								nxt_dev = `DEV_SLEEP;
							end else begin
								nxt_err = 1'b1;
								go_restart = 1'b1;
							end
						end
						default: ;
					endcase
				end
			end
			st_stop: begin
				if (wr & a_mode & req == `MODE_SLEEP) begin
					nxt_err = 1'b1;
					go_restart = 1'b1;
				end else if (wr_ok & a_mode & req == `MODE_NORMAL)
					nxt_state = st_normal;
			end
			st_sleep: begin
				// pending flags wake at once
				if (flags_set | wake_now)
					go_restart = 1'b1;
			end
			st_restart: begin
				if (rd_done & rst_n_ff)
					nxt_state = st_normal;
			end
			st_failsafe: begin
				if (wake_now)
					go_restart = 1'b1;
			end
			default: nxt_state = st_init;
		endcase

		// soft reset from init, normal or stop
		if (wr_ok & a_mode & req == `MODE_SOFT) begin
			nxt_state = st_init;
			nxt_ctrl  = (ctrl_ff & lk) | (`CTRL_RESET & ~lk);
			nxt_test  = 1'b0;
			nxt_cfg   = cfg_ff;
		end

		// supervisor events override software
		if (armed_ff & main_uv & (in_init | in_norm | in_stop)) begin
			nxt_muv = 1'b1;
			go_restart = 1'b1;
		end
		if (watchdog_fail & ~in_init & state_ff != st_sleep)
			go_restart = 1'b1;
		if (go_restart & state_ff != st_restart) begin
			nxt_state = st_restart;
			if (state_ff != st_sleep)
				nxt_dev = `DEV_RESTART;
			nxt_ctrl.aux_en = 1'b0;
			// transceiver comes back off or wake-capable
			nxt_ctrl.xcvr_mode = en_x ? `XCVR_WAKE : `XCVR_OFF;
		end
		if (failsafe_req) begin
			nxt_state = st_failsafe;
			nxt_dev = `DEV_RESTART;
		end
		// sleep forces an active transceiver to wake-capable
		if (nxt_state == st_sleep & (ctrl_ff.xcvr_mode == `XCVR_ON |
			ctrl_ff.xcvr_mode == `XCVR_RX))
			nxt_ctrl.xcvr_mode = `XCVR_WAKE;
	end

	// -----------------------------------------------------------------
	// state registers
	// -----------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (!nrst) begin
			state_ff   <= st_init;
			ctrl_ff    <= `CTRL_RESET;
			wflag_ff   <= '0;
			dev_ff     <= 2'h0;
			err_ff     <= 1'b0;
			muv_ff     <= 1'b0;
			buv_ff     <= 1'b0;
			failure_ff <= 1'b0;
			test_ff    <= 1'b0;
			prot_ff    <= 1'b0;
			cfg_ff     <= 1'b0;
		end else begin
			state_ff   <= nxt_state;
			ctrl_ff    <= nxt_ctrl;
			wflag_ff   <= nxt_wflag;
			dev_ff     <= nxt_dev;
			err_ff     <= nxt_err;
			muv_ff     <= nxt_muv;
			buv_ff     <= nxt_buv;
			failure_ff <= nxt_failure;
			test_ff    <= nxt_test;
			prot_ff    <= nxt_prot;
			cfg_ff     <= nxt_cfg;
		end
	end

	// reset delay: counts only while supply is good
	always_ff @(posedge clock) begin
		if (!nrst || main_uv || hold_rst)
			rd_cnt_ff <= 16'h0;
		else if (!rd_done)
			rd_cnt_ff <= rd_cnt_ff + 16'h1;
	end

	// reset output and the arming of undervolt restarts
	always_ff @(posedge clock) begin
		if (!nrst) begin
			rst_n_ff <= 1'b0;
			armed_ff <= 1'b0;
		end else begin
			rst_n_ff <= rd_done & ~main_uv &
				(nxt_state != st_sleep) &
				(nxt_state != st_failsafe) &
				~(go_restart_edge);
			if (rst_n_ff)
				armed_ff <= 1'b1;
		end
	end

	// -----------------------------------------------------------------
	// interrupt pulse
	// -----------------------------------------------------------------
	// normal and stop wakes, and stop entry with pending flags
	wire logic int_evt = (wake_now & (in_norm | in_stop)) |
		(nxt_state == st_stop & ~in_stop & flags_set);

	always_ff @(posedge clock) begin
		if (!nrst)
			int_cnt_ff <= 8'h0;
		else if (int_evt)
			int_cnt_ff <= 8'(INT_CYC);
		else if (int_cnt_ff != 8'h0)
			int_cnt_ff <= int_cnt_ff - 8'h1;
	end

	// -----------------------------------------------------------------
	// pin outputs, registered
	// -----------------------------------------------------------------
	wire logic live = (state_ff != st_failsafe);
	wire logic run  = in_norm | in_stop | in_init;
	power_mode_pkg::pin_out_type nxt_pins;
	assign nxt_pins = '{
		main_supply:  live & (state_ff != st_sleep),
		aux_supply:   ctrl_ff.aux_en & live &
			(state_ff != st_restart),
		pump:         ctrl_ff.pump_en & live,
		xcvr_mode:    live ? ctrl_ff.xcvr_mode : `XCVR_WAKE,
		gpio_cfg:     ctrl_ff.gpio_cfg,
		watchdog_en:  run | (state_ff == st_restart),
		cyclic_sense: ctrl_ff.cyclic_sense_en & live &
			(ctrl_ff.gpio_cfg == `GPIO_HS) & ctrl_ff.pin_wake_en &
			ctrl_ff.timer_wake_en,
		cyclic_wake:  ctrl_ff.cyclic_wake_en & live};

	// fail output: only after first release; test bit in normal only
	wire logic nxt_fail = armed_ff & (failure_ff |
		(test_ff & in_norm));

	logic fail_ff;
	logic int_ff;

	always_ff @(posedge clock) begin
		if (!nrst) begin
			pins     <= '0;
			mode     <= st_init;
			fail_ff  <= 1'b0;
			int_ff   <= 1'b0;
			rdata_ff <= 32'h0;
		end else begin
			pins     <= nxt_pins;
			mode     <= state_ff;
			fail_ff  <= nxt_fail;
			int_ff   <= (int_cnt_ff != 8'h0);
			if (psel & ~penable)
				rdata_ff <= rmux;
		end
	end

	assign reset_output_n     = rst_n_ff;
	assign fail_output_n      = ~fail_ff;
	assign interrupt_output_n = ~int_ff;

endmodule
`default_nettype wire

// file: include/power_mode_consts.svh
/*
 * register offsets, field positions, reset values, command codes and
 * timing figures of the operating-mode controller.
 * assumes a 32-bit apb slave and a 4 ns core clock.
 */
`ifndef POWER_MODE_CONSTS_SVH
`define POWER_MODE_CONSTS_SVH

// register byte offsets
`define OFS_MODE_CTRL   8'h00
`define OFS_SUPPLY_CTRL 8'h04
`define OFS_LOCK_CTRL   8'h08
`define OFS_WAKE_STAT   8'h0c
`define OFS_DEVICE_MODE_STATUS    8'h10
`define OFS_WD_REFRESH  8'h14

// mode request codes in mode control [1:0]
`define MODE_NORMAL 2'h0
`define MODE_SLEEP  2'h1
`define MODE_STOP   2'h2
`define MODE_SOFT   2'h3
`define POS_FAIL_TEST 2

// lock control bits
`define POS_LOCK_PROT 0
`define POS_LOCK_CFG  1

// device status fields
`define POS_CMD_ERR   2
`define POS_MAIN_UV   3
`define POS_BAT_UV    4
`define POS_FAILURE   5
`define DEV_RESTART   2'h1
`define DEV_SLEEP     2'h2

// supply control: reset value and config-lock mask (pump, gpio)
`define CTRL_RESET    12'h000
`define CTRL_CFG_MASK 12'h0e2

// transceiver and gpio codes
`define XCVR_OFF  2'h0
`define XCVR_WAKE 2'h1
`define XCVR_RX   2'h2
`define XCVR_ON   2'h3
`define GPIO_HS   3'h3
`define GPIO_WAKE 3'h4

// timing
`define CLK_NS          4
`define RESET_DELAY_NS  10000
`define INT_PULSE_NS    100

`endif

// file: include/power_mode_pkg.sv
/*
 * types of the operating-mode controller.
 * assumes the constants header is included by the design file.
 */
package power_mode_pkg;

	// operating modes
	typedef enum logic [2:0] {
		st_init,
		st_normal,
		st_stop,
		st_sleep,
		st_restart,
		st_failsafe
	} mode_state_type;

	// software supply and wake configuration, bit 11 first down to lsb
	typedef struct packed {
		logic       measure_route_enable; // [11]
		logic       cyclic_sense_en;      // [10]
		logic       cyclic_wake_en;       // [9]
		logic       timer_wake_en;        // [8]
		logic [2:0] gpio_cfg;             // [7:5]
		logic       pin_wake_en;          // [4]
		logic [1:0] xcvr_mode;            // [3:2]
		logic       pump_en;              // [1]
		logic       aux_en;               // [0]
	} supply_ctrl_type;

	// wake source flags
	typedef struct packed {
		logic timer;
		logic gpio;
		logic pin;
		logic xcvr;
	} wake_type;

	// pin-facing outputs
	typedef struct packed {
		logic       main_supply;
		logic       aux_supply;
		logic       pump;
		logic [1:0] xcvr_mode;
		logic [2:0] gpio_cfg;
		logic       watchdog_en;
		logic       cyclic_sense;
		logic       cyclic_wake;
	} pin_out_type;

endpackage

// file: bench/power_mode_properties.sv
/*
 * concurrent checks on the operating-mode controller's ports.
 * assumes one clock domain and the synchronous active-low reset.
 */
`timescale 1ns/100ps
`default_nettype none
module power_mode_properties (
	// clock and reset
	input wire logic                          clock,
	input wire logic                          nrst,
	// apb request side
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [7:0]                    paddr,
	input wire logic [31:0]                   pwdata,
	// monitors and wake
	input wire logic                          main_below_reset_threshold,
	input wire logic                          xcvr_wake,
	// outputs watched
	input wire power_mode_pkg::pin_out_type   pins,
	input wire power_mode_pkg::mode_state_type mode,
	input wire logic                          reset_output_n,
	input wire logic                          interrupt_output_n,
	input wire logic                          fail_output_n
);
	// ---------------------------------------------
	// helper decode and pulse length counter
	// ---------------------------------------------
	wire logic       wr_mode; // completed write to mode control
	wire logic       acc;     // any completed access
	wire logic       nwake;   // transceiver wake enabled in normal
	logic      [7:0] low_cnt_ff; // cycles the interrupt has been low
	assign acc = psel && penable;
	assign wr_mode = acc && pwrite && paddr == 8'h00;
	assign nwake = mode == power_mode_pkg::st_normal && pins.xcvr_mode != 2'h0;
	// restarts at every high level so a pulse is measured alone
	always_ff @(posedge clock) begin
		if (!nrst || interrupt_output_n)
			low_cnt_ff <= 8'h00;
		else
			low_cnt_ff <= low_cnt_ff + 8'h01;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_sleep_rails_off: assert property (mode == power_mode_pkg::st_sleep |-> !reset_output_n && !pins.main_supply && !pins.watchdog_en) else $error("sleep outputs wrong");
	a_main_stays_on: assert property (mode == power_mode_pkg::st_normal || mode == power_mode_pkg::st_stop |-> pins.main_supply) else $error("main supply off");
	a_stop_pins_frozen: assert property (mode == power_mode_pkg::st_stop [*3] |-> $past(pins) == $past(pins, 2)) else $error("pins moved in stop");
	a_int_pulse_len: assert property ($rose(interrupt_output_n) |-> low_cnt_ff == 8'h19) else $error("interrupt pulse length");
	a_wake_raises_int: assert property (nwake && $rose(xcvr_wake) |-> ##[1:10] !interrupt_output_n) else $error("no interrupt on wake");
	a_wake_keeps_mode: assert property (nwake && $rose(xcvr_wake) |=> (mode == power_mode_pkg::st_normal) [*8]) else $error("wake changed mode");
	a_stop_sleep_req: assert property (mode == power_mode_pkg::st_stop && wr_mode && pwdata[1:0] == 2'h1 |-> ##[1:3] mode == power_mode_pkg::st_restart) else $error("stop sleep request");
	a_init_any_frame: assert property (mode == power_mode_pkg::st_init && reset_output_n && acc && !wr_mode |-> ##[1:3] mode == power_mode_pkg::st_normal) else $error("init not left");
	a_soft_reset_init: assert property (mode == power_mode_pkg::st_normal && wr_mode && pwdata[1:0] == 2'h3 |-> ##[1:3] mode == power_mode_pkg::st_init) else $error("soft reset missed");
	a_fail_test_on: assert property (mode == power_mode_pkg::st_normal && $past(mode) == power_mode_pkg::st_normal && wr_mode && pwdata[2:0] == 3'h4 |-> ##[1:3] !fail_output_n) else $error("fail test ignored");
	a_no_early_fail: assert property (!reset_output_n && mode == power_mode_pkg::st_init |-> fail_output_n) else $error("early fail output");
	a_reset_while_low: assert property (main_below_reset_threshold [*6] |-> !reset_output_n) else $error("reset released early");
endmodule
bind power_mode_controller power_mode_properties u_power_mode_properties (
	.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.main_below_reset_threshold(main_below_reset_threshold),
	.xcvr_wake(xcvr_wake), .pins(pins), .mode(mode),
	.reset_output_n(reset_output_n), .interrupt_output_n(interrupt_output_n),
	.fail_output_n(fail_output_n));
`default_nettype wire

// file: bench/host_model.sv
/*
 * host side: counts interrupt pulses seen by the microcontroller.
 * assumes the interrupt is sampled on the block clock.
 */
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock and reset
	input wire logic  clock,
	input wire logic  nrst,
	// device outputs
	input wire logic  interrupt_output_n,
	// pulses seen
	output logic [7:0] int_count
);
	logic       prev_ff; // last sampled interrupt level
	logic [7:0] cnt_ff;  // falling edges so far
	assign int_count = cnt_ff;
	// a falling edge is one event; the pulse length is not needed here
	always_ff @(posedge clock) begin
		prev_ff <= interrupt_output_n;
		if (!nrst)
			cnt_ff <= 8'h00;
		else if (prev_ff && !interrupt_output_n)
			cnt_ff <= cnt_ff + 8'h01;
	end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
/*
 * self-checking bench of the operating-mode controller over apb.
 * assumes the reset delay is shortened to 40 ns for the run.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	// ---------------------------------------------
	// stimulus, observation and bookkeeping
	// ---------------------------------------------
	logic clock, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, int_count;
	logic [31:0] pwdata, prdata, rd;
	logic mbelow, bat_uv, xw, rst_n, int_n, fail_n, wdr;
	logic zero; // quiet event inputs
	power_mode_pkg::pin_out_type pins;
	power_mode_pkg::mode_state_type mode;
	int errors, checked;
	int wd_count; // accepted watchdog refresh pulses
	power_mode_controller #(.RESET_DELAY_NS(40)) u_power_mode_controller (
		.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr),
		.main_below_reset_threshold(mbelow), .battery_below_uv(bat_uv),
		.xcvr_wake(xw), .wake_sense_pin(zero), .gpio_wake(zero),
		.timer_wake(zero), .watchdog_fail(zero), .failsafe_req(zero),
		.pins(pins), .mode(mode), .reset_output_n(rst_n),
		.interrupt_output_n(int_n), .fail_output_n(fail_n),
		.watchdog_refresh(wdr));
	host_model u_host_model (.clock(clock), .nrst(nrst),
		.interrupt_output_n(int_n), .int_count(int_count));
	// counts refresh pulses in the access cycle of a write
	always @(posedge clock) begin
		if (wdr === 1'b1)
			wd_count++;
	end
	// free-running core clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read", e, rd);
	endtask
	// bounded waits; a miss shows up as a mismatch
	task automatic wait_mode(input power_mode_pkg::mode_state_type m);
		int i;
		for (i = 0; i < 400 && mode !== m; i++) @(posedge clock);
		chk("mode", {29'h0, m}, {29'h0, mode});
	endtask
	task automatic wait_int(input logic [7:0] n);
		int i;
		for (i = 0; i < 60 && int_count !== n; i++) @(posedge clock);
		chk("interrupts", n, int_count);
	endtask
	task automatic wait_rst();
		int i;
		for (i = 0; i < 400 && rst_n !== 1'b1; i++) @(posedge clock);
		chk("reset out", 1, rst_n);
	endtask
	task automatic end_sim();
		$display("errors %0d checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ---------------------------------------------
	// main sequence
	// ---------------------------------------------
	initial begin
		{nrst, psel, penable, pwrite, xw, zero} = 6'h00;
		{mbelow, bat_uv} = 2'h3;
		paddr = 8'h00;
		pwdata = 32'h0;
		errors = 0;
		checked = 0;
		wd_count = 0;
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (20) @(posedge clock);
		chk("reset out", 0, rst_n);
		chk("fail out", 1, fail_n);
		mbelow <= 1'b0;
		wait_rst();
		repeat (4) @(posedge clock);
		rdc(8'h10, 32'h10);
		bat_uv <= 1'b0;
		wait_mode(power_mode_pkg::st_normal);
		chk("rails", 5'h10, {pins.main_supply, pins.aux_supply, pins.pump,
			pins.xcvr_mode});
		wr(8'h04, 32'hf);
		@(posedge clock);
		chk("rails", 5'h1f, {pins.main_supply, pins.aux_supply, pins.pump,
			pins.xcvr_mode});
		wr(8'h08, 32'h2);
		wr(8'h04, 32'hd);
		rdc(8'h04, 32'hf);
		wr(8'h08, 32'h0);
		wr(8'h04, 32'hd);
		rdc(8'h04, 32'hd);
		wr(8'h00, 32'h4);
		@(posedge clock);
		chk("fail test", 0, fail_n);
		wr(8'h00, 32'h0);
		@(posedge clock);
		chk("fail test", 1, fail_n);
		xw <= 1'b1;
		wait_int(8'h01);
		chk("mode", 1, mode);
		xw <= 1'b0;
		repeat (40) @(posedge clock);
		wr(8'h00, 32'h2);
		wait_mode(power_mode_pkg::st_stop);
		wait_int(8'h02);
		chk("main on", 1, pins.main_supply);
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'hd);
		apb(1'b0, 8'h10, 32'h0);
		chk("cmd error", 1, rd[2]);
		wr(8'h10, 32'h4);
		wr(8'h14, 32'h0);
		chk("wd refresh", 1, wd_count);
		wr(8'h00, 32'h1);
		wait_mode(power_mode_pkg::st_restart);
		wait_mode(power_mode_pkg::st_normal);
		apb(1'b0, 8'h10, 32'h0);
		chk("cmd error", 1, rd[2]);
		chk("xcvr", 1, pins.xcvr_mode);
		wr(8'h04, 32'h0);
		wr(8'h0c, 32'hf);
		wr(8'h00, 32'h1);
		wait_mode(power_mode_pkg::st_restart);
		wait_mode(power_mode_pkg::st_normal);
		wr(8'h04, 32'h4);
		wr(8'h0c, 32'hf);
		wr(8'h10, 32'h3f);
		wr(8'h00, 32'h1);
		wait_mode(power_mode_pkg::st_sleep);
		chk("sleep outs", 0, {rst_n, pins.main_supply, pins.watchdog_en});
		xw <= 1'b1;
		wait_mode(power_mode_pkg::st_restart);
		wait_mode(power_mode_pkg::st_normal);
		rdc(8'h0c, 32'h1);
		apb(1'b0, 8'h10, 32'h0);
		chk("dev status", 2, rd[1:0]);
		xw <= 1'b0;
		mbelow <= 1'b1;
		wait_mode(power_mode_pkg::st_restart);
		chk("reset out", 0, rst_n);
		mbelow <= 1'b0;
		wait_mode(power_mode_pkg::st_normal);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", 1, err);
		chk("unmapped", 0, rd);
		wr(8'h04, 32'h570);
		@(posedge clock);
		chk("cyclic sense", 1, pins.cyclic_sense);
		wr(8'h04, 32'h1);
		wr(8'h08, 32'h1);
		wr(8'h00, 32'h3);
		wait_mode(power_mode_pkg::st_init);
		wait_rst();
		rdc(8'h08, 32'h1);
		wait_mode(power_mode_pkg::st_normal);
		wr(8'h04, 32'h2);
		rdc(8'h04, 32'h1);
		end_sim();
	end
	// hang guard, well beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
